/* core/cswk_pkg.sv */
// package for the selective-wake control block
// assumes a single 125 MHz clock domain
package cswk_pkg;
   localparam int          CLK_MHZ        = 125;
   localparam int          SILENCE_MS     = 600;
   localparam int          SILENCE_CYC    = SILENCE_MS * 1000 * CLK_MHZ;
   localparam logic [2:0]  MODE_OFF       = 3'h0;
   localparam logic [2:0]  MODE_WK        = 3'h1;
   localparam logic [2:0]  MODE_SWK       = 3'h5;
   localparam logic [5:0]  FRAME_ERROR_COUNT_OVF       = 6'h20;
   localparam logic [5:0]  FRAME_ERROR_COUNT_ZERO      = 6'h00;
   localparam logic [1:0]  TRIM_UNLOCK    = 2'h3;
   localparam logic [7:0]  ADDR_MODE      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;
   localparam logic [7:0]  ADDR_CFG       = 8'h08;
   localparam logic [7:0]  ADDR_QUANTA    = 8'h0c;
   localparam logic [7:0]  ADDR_SAMPLE    = 8'h10;
   localparam logic [7:0]  ADDR_CNT_HI    = 8'h14;
   localparam logic [7:0]  ADDR_CNT_LO    = 8'h18;
   localparam logic [7:0]  ADDR_TRIM      = 8'h1c;
   localparam logic [7:0]  ADDR_TRIM_OPT  = 8'h20;
   localparam logic [7:0]  ADDR_FD_FILT   = 8'h24;
   localparam logic [5:0]  QUANTA_RST     = 6'h08;
   localparam logic [5:0]  SAMPLE_RST     = 6'h33;
   localparam logic [7:0]  FD_FILT_RST    = 8'h04;
   typedef enum logic [1:0] {
      SBC_NORMAL  = 2'b00,
      SBC_STOP    = 2'b01,
      SBC_SLEEP   = 2'b10,
      SBC_RESTART = 2'b11
   } cswk_sbc_t;
endpackage : cswk_pkg

/* core/cswk_top.sv */
// selective-wake control: mode remap, wake flags, error counter, osc measure
// assumes frame decode events arrive as one-cycle pulses from a CAN decoder
//
// Contract
// - normal restart: off kept, active becomes 001
// - normal restart: selective codes read 101, error set
// - wake frame in sleep: 101, both wake flags
// - counter overflow wake: error set, count 100000
// - failed config: pattern wakes, error flag set
// - plain wake mode: pattern wakes, flags set
// - other wake source: CAN flags clear, mode kept
// - pattern flag follows frame flag only in silent-window
// - fail-safe forces wake mode, selective off
// - CAN wake: restart asleep, interrupt otherwise
// - decoder timing from quanta, sample, receiver select
// - measure pulse length on transmit input
// - trim writes only when unlocked and measuring
// - tolerant mode ignores fast frames, no wake
// - decoder ready again after fast frame end
// - EDL bit classifies frame type
// - fast dominant needs filter minimum length
// - tolerant off: count up errors, down good
// - tolerant on, hold off: down on good
// - tolerant and hold: counter held zero
// - hold bit cleared at silence timeout
// - silence timeout 0.6 to 1.2 seconds
`timescale 1ns/1ps
module cswk_top #(
   parameter int SILENCE_CYCLES = cswk_pkg::SILENCE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic [1:0]  sbc_mode_i,
   input  wire logic        fail_safe_i,
   input  wire logic        other_wake_i,
   input  wire logic        bus_active_i,
   input  wire logic        can_transmit_input_i,
   input  wire logic        wake_pattern_i,
   input  wire logic        frame_done_i,
   input  wire logic        frame_ok_i,
   input  wire logic        frame_match_i,
   input  wire logic        edl_bit_i,
   input  wire logic        frame_eof_i,
   input  wire logic [7:0]  dominant_len_i,
   output logic             restart_req_o,
   output logic             wake_irq_o,
   output logic             decoder_busy_o,
   output logic             fast_dominant_o,
   output logic [5:0]       quanta_per_bit_o,
   output logic [5:0]       sample_point_setting_o,
   output logic [1:0]       recovery_clock_select_o,
   output logic             wake_receiver_select_o,
   output logic [2:0]       can_mode_o
);
   logic [2:0]  mode_r;
   logic        swk_config_error_flag_r;
   logic        can_wake_flag_r;
   logic        wake_pattern_flag_r;
   logic        wake_frame_flag_r;
   logic        silence_flag_r;
   logic [5:0]  frame_error_count_r;
   logic        fd_tolerant_enable_r;
   logic        error_count_hold_r;
   logic        osc_measure_enable_r;
   logic [1:0]  trim_unlock_r;
   logic [7:0]  osc_trim_value_r;
   logic [7:0]  osc_trim_option_r;
   logic [7:0]  fd_filter_r;
   logic [15:0] osc_count_r;
   logic [15:0] osc_run_r;
   logic        txd_d_r;
   logic [31:0] silence_cnt_r;
   logic        fd_skip_r;
   logic [1:0]  sbc_prev_r;
   logic        hold_clr_r;
   logic        wake_ev;
   logic        silence_hit;
   logic        trim_open;
   logic        good_frame;
   logic        bad_frame;
   cswk_pkg::cswk_sbc_t sbc;

   assign sbc         = cswk_pkg::cswk_sbc_t'(sbc_mode_i);
   assign silence_hit = (silence_cnt_r == SILENCE_CYCLES - 1);
   assign trim_open   = (trim_unlock_r == cswk_pkg::TRIM_UNLOCK) && osc_measure_enable_r;

   function automatic logic is_swk(input logic [2:0] m);
      is_swk = m[2] && (m != 3'h4);
   endfunction : is_swk

   function automatic logic wr_at(input logic [7:0] a);
      wr_at = wr_i && (addr_i == a);
   endfunction : wr_at

   // frames while the decoder is active; fast frames skipped when tolerant
   assign good_frame = frame_done_i && !fd_skip_r && frame_ok_i && !edl_bit_i;
   assign bad_frame  = frame_done_i && !fd_skip_r && (!frame_ok_i || edl_bit_i)
                       && !fd_tolerant_enable_r;

   // fast-frame skip: set on EDL=1 in tolerant mode, cleared at its end of frame
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fd_skip_r <= 1'b0;
      end else if (fd_skip_r && frame_eof_i) begin
         fd_skip_r <= 1'b0;
      end else if (fd_tolerant_enable_r && edl_bit_i && frame_done_i) begin
         fd_skip_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fast_dominant_o <= 1'b0;
         decoder_busy_o  <= 1'b0;
      end else begin
         fast_dominant_o <= fd_tolerant_enable_r && (dominant_len_i >= fd_filter_r);
         decoder_busy_o  <= fd_skip_r;
      end
   end

   // silence timer
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         silence_cnt_r  <= 32'h0;
         silence_flag_r <= 1'b0;
      end else if (bus_active_i) begin
         silence_cnt_r  <= 32'h0;
         silence_flag_r <= 1'b0;
      end else if (silence_hit) begin
         silence_flag_r <= 1'b1;
      end else begin
         silence_cnt_r <= silence_cnt_r + 32'h1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold_clr_r <= 1'b0;
      end else begin
         hold_clr_r <= silence_hit && !silence_flag_r && !bus_active_i;
      end
   end

   // error counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_error_count_r <= cswk_pkg::FRAME_ERROR_COUNT_ZERO;
      end else if (fd_tolerant_enable_r && error_count_hold_r) begin
         frame_error_count_r <= cswk_pkg::FRAME_ERROR_COUNT_ZERO;
      end else if (bad_frame && frame_error_count_r != cswk_pkg::FRAME_ERROR_COUNT_OVF) begin
         frame_error_count_r <= frame_error_count_r + 6'h1;
      end else if ((good_frame || (fd_tolerant_enable_r && frame_eof_i && fd_skip_r))
                   && frame_error_count_r != cswk_pkg::FRAME_ERROR_COUNT_ZERO
                   && frame_error_count_r != cswk_pkg::FRAME_ERROR_COUNT_OVF) begin
         frame_error_count_r <= frame_error_count_r - 6'h1;
      end
   end

   // oscillator measure
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         txd_d_r     <= 1'b1;
         osc_run_r   <= 16'h0;
         osc_count_r <= 16'h0;
      end else begin
         txd_d_r <= can_transmit_input_i;
         if (osc_measure_enable_r && mode_r == cswk_pkg::MODE_OFF) begin
            if (!can_transmit_input_i) begin
               osc_run_r <= osc_run_r + 16'h1;
            end else if (!txd_d_r) begin
               osc_count_r <= osc_run_r;
               osc_run_r   <= 16'h0;
            end
         end
      end
   end

   // wake and mode control
   assign wake_ev = (sbc != cswk_pkg::SBC_RESTART) && (
      (is_swk(mode_r) && !swk_config_error_flag_r && frame_done_i && frame_match_i
       && frame_ok_i && !edl_bit_i && !fd_skip_r)
      || (is_swk(mode_r) && !swk_config_error_flag_r
          && frame_error_count_r == cswk_pkg::FRAME_ERROR_COUNT_OVF)
      || (mode_r != cswk_pkg::MODE_OFF && mode_r != 3'h4 && wake_pattern_i
          && (!is_swk(mode_r) || swk_config_error_flag_r)));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_r                  <= cswk_pkg::MODE_OFF;
         swk_config_error_flag_r <= 1'b0;
         can_wake_flag_r         <= 1'b0;
         wake_pattern_flag_r     <= 1'b0;
         wake_frame_flag_r       <= 1'b0;
         sbc_prev_r              <= 2'b00;
         restart_req_o           <= 1'b0;
         wake_irq_o              <= 1'b0;
      end else begin
         sbc_prev_r    <= sbc_mode_i;
         restart_req_o <= 1'b0;
         wake_irq_o    <= 1'b0;
         if (wr_at(cswk_pkg::ADDR_MODE)) begin
            mode_r <= wdata_i[2:0];
         end
         if (wr_at(cswk_pkg::ADDR_STATUS)) begin
            if (wdata_i[0]) swk_config_error_flag_r <= 1'b0;
            if (wdata_i[1]) can_wake_flag_r <= 1'b0;
            if (wdata_i[2]) wake_pattern_flag_r <= 1'b0;
            if (wdata_i[3]) wake_frame_flag_r <= 1'b0;
         end
         if (fail_safe_i) begin
            mode_r <= cswk_pkg::MODE_WK;
         end else if (sbc == cswk_pkg::SBC_RESTART
                      && sbc_prev_r == 2'(cswk_pkg::SBC_NORMAL)) begin
            if (is_swk(mode_r)) begin
               mode_r                  <= cswk_pkg::MODE_SWK;
               swk_config_error_flag_r <= 1'b1;
            end else if (mode_r[2:1] == 2'b01) begin
               mode_r <= cswk_pkg::MODE_WK;
            end
         end
         if (wake_ev) begin
            can_wake_flag_r <= 1'b1;
            if (sbc == cswk_pkg::SBC_SLEEP) begin
               restart_req_o <= 1'b1;
            end else begin
               wake_irq_o <= 1'b1;
            end
            if (wake_pattern_i) begin
               wake_pattern_flag_r <= 1'b1;
            end
            if (is_swk(mode_r) && !swk_config_error_flag_r) begin
               if (frame_error_count_r == cswk_pkg::FRAME_ERROR_COUNT_OVF) begin
                  swk_config_error_flag_r <= 1'b1;
               end else begin
                  wake_frame_flag_r <= 1'b1;
                  if (silence_flag_r) wake_pattern_flag_r <= 1'b1;
               end
            end
         end
         // other wake sources leave CAN flags and mode alone
         if (other_wake_i && sbc == cswk_pkg::SBC_SLEEP) begin
            restart_req_o <= 1'b1;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fd_tolerant_enable_r    <= 1'b0;
         error_count_hold_r      <= 1'b0;
         osc_measure_enable_r    <= 1'b0;
         trim_unlock_r           <= 2'h0;
         wake_receiver_select_o  <= 1'b0;
         recovery_clock_select_o <= 2'h0;
      end else begin
         if (wr_at(cswk_pkg::ADDR_CFG)) begin
            fd_tolerant_enable_r    <= wdata_i[0];
            error_count_hold_r      <= wdata_i[1];
            osc_measure_enable_r    <= wdata_i[2];
            trim_unlock_r           <= wdata_i[4:3];
            wake_receiver_select_o  <= wdata_i[5];
            recovery_clock_select_o <= wdata_i[7:6];
         end
         if (hold_clr_r) begin
            error_count_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         quanta_per_bit_o       <= cswk_pkg::QUANTA_RST;
         sample_point_setting_o <= cswk_pkg::SAMPLE_RST;
         fd_filter_r            <= cswk_pkg::FD_FILT_RST;
         osc_trim_value_r       <= 8'h0;
         osc_trim_option_r      <= 8'h0;
      end else begin
         if (wr_at(cswk_pkg::ADDR_QUANTA)) quanta_per_bit_o <= wdata_i[5:0];
         if (wr_at(cswk_pkg::ADDR_SAMPLE)) sample_point_setting_o <= wdata_i[5:0];
         if (wr_at(cswk_pkg::ADDR_FD_FILT)) fd_filter_r <= wdata_i[7:0];
         if (wr_at(cswk_pkg::ADDR_TRIM) && trim_open) osc_trim_value_r <= wdata_i[7:0];
         if (wr_at(cswk_pkg::ADDR_TRIM_OPT) && trim_open) begin
            osc_trim_option_r <= wdata_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         can_mode_o <= cswk_pkg::MODE_OFF;
      end else begin
         can_mode_o <= mode_r;
      end
   end

   // read port
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0;
      end else if (rd_i) begin
         if (addr_i == cswk_pkg::ADDR_MODE) begin
            rdata_o <= {29'h0, mode_r};
         end else if (addr_i == cswk_pkg::ADDR_STATUS) begin
            rdata_o <= {21'h0, frame_error_count_r, silence_flag_r, wake_frame_flag_r,
                        wake_pattern_flag_r, can_wake_flag_r, swk_config_error_flag_r};
         end else if (addr_i == cswk_pkg::ADDR_CFG) begin
            rdata_o <= {24'h0, recovery_clock_select_o, wake_receiver_select_o,
                        trim_unlock_r, osc_measure_enable_r, error_count_hold_r,
                        fd_tolerant_enable_r};
         end else if (addr_i == cswk_pkg::ADDR_QUANTA) begin
            rdata_o <= {26'h0, quanta_per_bit_o};
         end else if (addr_i == cswk_pkg::ADDR_SAMPLE) begin
            rdata_o <= {26'h0, sample_point_setting_o};
         end else if (addr_i == cswk_pkg::ADDR_CNT_HI) begin
            rdata_o <= {24'h0, osc_count_r[15:8]};
         end else if (addr_i == cswk_pkg::ADDR_CNT_LO) begin
            rdata_o <= {24'h0, osc_count_r[7:0]};
         end else if (addr_i == cswk_pkg::ADDR_TRIM) begin
            rdata_o <= {24'h0, osc_trim_value_r};
         end else if (addr_i == cswk_pkg::ADDR_TRIM_OPT) begin
            rdata_o <= {24'h0, osc_trim_option_r};
         end else if (addr_i == cswk_pkg::ADDR_FD_FILT) begin
            rdata_o <= {24'h0, fd_filter_r};
         end else begin
            rdata_o <= 32'h0;
         end
      end else begin
         rdata_o <= 32'h0;
      end
   end

   // checks
   fail_safe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fail_safe_i |=> mode_r == cswk_pkg::MODE_WK) else $error("fail-safe mode wrong");
   hold_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fd_tolerant_enable_r && error_count_hold_r |=> frame_error_count_r == 6'h0)
      else $error("held counter not zero");
   trim_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_at(cswk_pkg::ADDR_TRIM) && !trim_open |=> $stable(osc_trim_value_r))
      else $error("trim written while locked");
   wake_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_ev |=> can_wake_flag_r) else $error("wake flag not set");
   fd_nowake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fd_skip_r |=> !wake_frame_flag_r || $past(wake_frame_flag_r))
      else $error("woke on fast frame");
   sequence normal_restart_s;
      sbc == cswk_pkg::SBC_RESTART && sbc_prev_r == 2'(cswk_pkg::SBC_NORMAL) && !fail_safe_i;
   endsequence
   swk_remap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      normal_restart_s ##0 is_swk(mode_r)
      |=> mode_r == cswk_pkg::MODE_SWK && swk_config_error_flag_r)
      else $error("selective restart remap wrong");
   active_remap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      normal_restart_s ##0 mode_r[2:1] == 2'b01 |=> mode_r == cswk_pkg::MODE_WK)
      else $error("active restart remap wrong");
endmodule : cswk_top

/* testbench/cswk_can_model.sv */
// bus-side partner: frame decode events, wake pattern, bus activity
// assumes one caller process; events are one-cycle pulses on clk_i
`timescale 1ns/1ps
module cswk_can_model (
   input  wire logic       clk_i,
   output logic            pattern_o,
   output logic            done_o,
   output logic            ok_o,
   output logic            match_o,
   output logic            edl_o,
   output logic            eof_o,
   output logic            active_o,
   output logic [7:0]      dom_len_o
);
   initial begin
      {pattern_o, done_o, eof_o, ok_o, match_o, edl_o} = '0;
      active_o = 1'b1;
      dom_len_o = 8'h00;
   end
   // qualifiers are inverted once the pulse is gone
   task automatic frame(input logic ok, input logic mt, input logic edl);
      @(posedge clk_i);
      done_o <= 1'b1;
      {ok_o, match_o, edl_o} <= {ok, mt, edl};
      @(posedge clk_i);
      done_o <= 1'b0;
      {ok_o, match_o, edl_o} <= ~{ok, mt, edl};
      repeat (3) @(posedge clk_i);
   endtask : frame
   task automatic pulse(input int which);
      @(posedge clk_i);
      if (which == 0) pattern_o <= 1'b1;
      else eof_o <= 1'b1;
      @(posedge clk_i);
      {pattern_o, eof_o} <= 2'b00;
      repeat (3) @(posedge clk_i);
   endtask : pulse
   task automatic quiet(input int n);
      @(posedge clk_i);
      active_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      active_o <= 1'b1;
   endtask : quiet
   task automatic dom(input logic [7:0] v);
      @(posedge clk_i);
      dom_len_o <= v;
      repeat (3) @(posedge clk_i);
   endtask : dom
endmodule : cswk_can_model

/* testbench/cswk_top_bench.sv */
// self-checking bench for the selective-wake control block
// assumes a shortened silence count and the bus-side partner model
`timescale 1ns/1ps
module cswk_top_bench;
   localparam int SIL = 50;
   typedef struct packed {logic [2:0] code; logic [2:0] mode; logic err;} cswk_row_t;
   logic        clk_i, rst_i, wr_i, rd_i, fail_safe_i, other_wake_i, can_transmit_input_i;
   logic        wake_pattern_i, frame_done_i, frame_ok_i, frame_match_i, edl_bit_i;
   logic        frame_eof_i, bus_active_i, restart_req_o, wake_irq_o, decoder_busy_o;
   logic        fast_dominant_o, wake_receiver_select_o;
   logic [7:0]  addr_i, dominant_len_i;
   logic [31:0] wdata_i, rdata_o, d, hi;
   logic [1:0]  sbc_mode_i, recovery_clock_select_o;
   logic [5:0]  quanta_per_bit_o, sample_point_setting_o;
   logic [2:0]  can_mode_o;
   int          n_errors = 0, checks_done = 0, n_restart = 0, n_irq = 0, cyc = 0, r0;
   cswk_row_t   rows [8];
   cswk_top #(.SILENCE_CYCLES(SIL)) cswk_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sbc_mode_i(sbc_mode_i), .fail_safe_i(fail_safe_i), .other_wake_i(other_wake_i),
      .bus_active_i(bus_active_i), .can_transmit_input_i(can_transmit_input_i),
      .wake_pattern_i(wake_pattern_i), .frame_done_i(frame_done_i),
      .frame_ok_i(frame_ok_i), .frame_match_i(frame_match_i), .edl_bit_i(edl_bit_i),
      .frame_eof_i(frame_eof_i), .dominant_len_i(dominant_len_i),
      .restart_req_o(restart_req_o), .wake_irq_o(wake_irq_o),
      .decoder_busy_o(decoder_busy_o), .fast_dominant_o(fast_dominant_o),
      .quanta_per_bit_o(quanta_per_bit_o), .sample_point_setting_o(sample_point_setting_o),
      .recovery_clock_select_o(recovery_clock_select_o),
      .wake_receiver_select_o(wake_receiver_select_o), .can_mode_o(can_mode_o));
   cswk_can_model cswk_can_model_inst (.clk_i(clk_i), .pattern_o(wake_pattern_i),
      .done_o(frame_done_i), .ok_o(frame_ok_i), .match_o(frame_match_i),
      .edl_o(edl_bit_i), .eof_o(frame_eof_i), .active_o(bus_active_i),
      .dom_len_o(dominant_len_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (restart_req_o === 1'b1) n_restart++;
      if (wake_irq_o === 1'b1) n_irq++;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      d = rdata_o;
   endtask : rd
   task automatic sbc(input cswk_pkg::cswk_sbc_t m);
      @(posedge clk_i);
      sbc_mode_i <= m;
      repeat (3) @(posedge clk_i);
   endtask : sbc
   task automatic st(input logic [31:0] m, input logic [31:0] e);
      rd(cswk_pkg::ADDR_STATUS);
      chk("status", d & m, e);
   endtask : st
   // back to normal, program the mode, clear the wake flags, mark the restart count
   task automatic md(input logic [2:0] c);
      sbc(cswk_pkg::SBC_NORMAL);
      wr(cswk_pkg::ADDR_MODE, {29'h0, c});
      wr(cswk_pkg::ADDR_STATUS, 32'h0000000f);
      r0 = n_restart;
   endtask : md
   task automatic wk(input int n);
      repeat (4) @(posedge clk_i);
      chk("restarts", n_restart - r0, n);
   endtask : wk
   initial begin
      rows = '{{3'h0, 3'h0, 1'b0}, {3'h1, 3'h1, 1'b0}, {3'h2, 3'h1, 1'b0},
               {3'h3, 3'h1, 1'b0}, {3'h4, 3'h4, 1'b0}, {3'h5, 3'h5, 1'b1},
               {3'h6, 3'h5, 1'b1}, {3'h7, 3'h5, 1'b1}};
      {rst_i, wr_i, rd_i, fail_safe_i, other_wake_i} = 5'b10000;
      {addr_i, wdata_i} = '0;
      sbc_mode_i = cswk_pkg::SBC_NORMAL;
      can_transmit_input_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("quanta", quanta_per_bit_o, cswk_pkg::QUANTA_RST);
      chk("sample", sample_point_setting_o, cswk_pkg::SAMPLE_RST);
      rd(8'hfc);
      chk("unmapped", d, 32'h0);
      foreach (rows[i]) begin
         md(rows[i].code);
         sbc(cswk_pkg::SBC_RESTART);
         rd(cswk_pkg::ADDR_MODE);
         chk("mode", d, rows[i].mode);
         st(32'h1, rows[i].err);
      end
      // error flag left set by the last row: a pattern still wakes
      sbc(cswk_pkg::SBC_SLEEP);
      r0 = n_restart;
      cswk_can_model_inst.pulse(0);
      wk(1);
      st(32'h7ef, 32'h7);
      md(3'h5);
      sbc(cswk_pkg::SBC_SLEEP);
      cswk_can_model_inst.frame(0, 0, 0);
      st(32'h7e0, 32'h20);
      cswk_can_model_inst.frame(1, 0, 0);
      st(32'h7e0, 32'h0);
      cswk_can_model_inst.frame(1, 0, 1);
      st(32'h7e0, 32'h20);
      wr(cswk_pkg::ADDR_CFG, 32'h1);
      cswk_can_model_inst.frame(1, 1, 1);
      chk("busy", decoder_busy_o, 1'b1);
      cswk_can_model_inst.pulse(1);
      chk("busy", decoder_busy_o, 1'b0);
      wk(0);
      st(32'h7e0, 32'h0);
      cswk_can_model_inst.dom(cswk_pkg::FD_FILT_RST - 8'h1);
      chk("fast", fast_dominant_o, 1'b0);
      cswk_can_model_inst.dom(cswk_pkg::FD_FILT_RST);
      chk("fast", fast_dominant_o, 1'b1);
      wr(cswk_pkg::ADDR_CFG, 32'h0);
      cswk_can_model_inst.frame(0, 0, 0);
      wr(cswk_pkg::ADDR_CFG, 32'h3);
      st(32'h7e0, 32'h0);
      // status is read while the bus is still silent
      fork
         cswk_can_model_inst.quiet(SIL + 30);
         begin
            repeat (SIL + 10) @(posedge clk_i);
            rd(cswk_pkg::ADDR_CFG);
            chk("hold", d[1], 1'b0);
            st(32'h10, 32'h10);
         end
      join
      wr(cswk_pkg::ADDR_CFG, 32'h0);
      wr(cswk_pkg::ADDR_STATUS, 32'h0000000f);
      cswk_can_model_inst.frame(1, 1, 0);
      wk(1);
      st(32'h00f, 32'h00a);
      md(3'h5);
      sbc(cswk_pkg::SBC_SLEEP);
      for (int i = 0; i < 40 && n_restart == r0; i++) cswk_can_model_inst.frame(0, 0, 0);
      wk(1);
      st(32'h7eb, 32'h403);
      md(3'h1);
      sbc(cswk_pkg::SBC_SLEEP);
      cswk_can_model_inst.pulse(0);
      wk(1);
      st(32'h00f, 32'h006);
      md(3'h1);
      sbc(cswk_pkg::SBC_SLEEP);
      @(posedge clk_i);
      other_wake_i <= 1'b1;
      @(posedge clk_i);
      other_wake_i <= 1'b0;
      wk(1);
      sbc(cswk_pkg::SBC_RESTART);
      st(32'h00a, 32'h0);
      rd(cswk_pkg::ADDR_MODE);
      chk("mode", d, cswk_pkg::MODE_WK);
      md(3'h1);
      r0 = n_irq;
      cswk_can_model_inst.pulse(0);
      chk("irq", n_irq - r0, 1);
      wr(cswk_pkg::ADDR_QUANTA, 32'h12);
      wr(cswk_pkg::ADDR_SAMPLE, 32'h2a);
      wr(cswk_pkg::ADDR_CFG, 32'ha0);
      @(posedge clk_i);
      chk("rx", {quanta_per_bit_o, sample_point_setting_o, recovery_clock_select_o,
          wake_receiver_select_o}, {6'h12, 6'h2a, 2'h2, 1'b1});
      md(3'h0);
      wr(cswk_pkg::ADDR_CFG, 32'h4);
      can_transmit_input_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      can_transmit_input_i <= 1'b1;
      rd(cswk_pkg::ADDR_CNT_HI);
      hi = d;
      rd(cswk_pkg::ADDR_CNT_LO);
      d = {hi[7:0], d[7:0]};
      chk("count", d >= 19 && d <= 21, 1);
      wr(cswk_pkg::ADDR_TRIM, 32'h5a);
      rd(cswk_pkg::ADDR_TRIM);
      chk("trim", d, 32'h0);
      wr(cswk_pkg::ADDR_CFG, 32'h1c);
      wr(cswk_pkg::ADDR_TRIM, 32'h5a);
      wr(cswk_pkg::ADDR_TRIM_OPT, 32'h3c);
      wr(cswk_pkg::ADDR_CFG, 32'h4);
      rd(cswk_pkg::ADDR_TRIM);
      hi = d;
      rd(cswk_pkg::ADDR_TRIM_OPT);
      chk("trim", {hi[7:0], d[7:0]}, 32'h5a3c);
      md(3'h7);
      fail_safe_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("failsafe", can_mode_o, cswk_pkg::MODE_WK);
      // reset in mid-run brings settings back
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("quanta", quanta_per_bit_o, cswk_pkg::QUANTA_RST);
      @(posedge clk_i);
      rd(cswk_pkg::ADDR_CFG);
      chk("cfg", d, 32'h0);
      finish_test();
   end
endmodule : cswk_top_bench
